/* File: cshk_bus_model.sv */
// Purpose: CAN bus far side seen by the receive pins
// Assumes: Bench picks dominant or recessive per channel
// Notes: Level follows the polarity the channel expects
`timescale 1ns/1ps
module cshk_bus_model (
   // Bus request from bench
   input wire logic [1:0] dom,
   input wire logic [1:0] pol,
   // Receive pins
   output logic ch1_rx_pin,
   output logic ch2_rx_pin
);
   // Recessive is the inverse of the dominant level
   assign ch1_rx_pin = dom[0] ? pol[0] : ~pol[0];
   assign ch2_rx_pin = dom[1] ? pol[1] : ~pol[1];
endmodule // cshk_bus_model

/* File: cshk_chan.sv */
// Purpose: One CAN channel: init/standby mode and pending flags
// Assumes: Bus level already mapped to recessive indication
// Notes: Flags use set-wins-over-clear
`timescale 1ns/1ps
module cshk_chan
   import cshk_pkg::*;
#(
   parameter int NEVT = cshk_pkg::CSHK_NEVT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Mode control
   input wire logic init_set,
   input wire logic init_clr,
   input wire logic stby_set,
   input wire logic stby_clr,
   input wire logic bus_recessive,
   // Pending flags
   input wire logic [NEVT-1:0] evt,
   input wire logic [NEVT-1:0] pend_clr,
   output logic [NEVT-1:0] pend_r,
   output cshk_pkg::cshk_ch_state_t state_r
);
   import cshk_pkg::*;
   cshk_ch_state_t state_nxt;
   logic [NEVT-1:0] pend_nxt;
   // Set wins: an event in the clear cycle survives
   assign pend_nxt = (pend_r & ~pend_clr) | evt;
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         CSHK_CH_RUN: begin
            // Entry refused while bus shows dominant
            if (init_set && bus_recessive) begin
               state_nxt = CSHK_CH_INIT;
            end else if (stby_set && bus_recessive) begin
               state_nxt = CSHK_CH_STBY;
            end
         end
         CSHK_CH_INIT: begin
            if (init_clr && !init_set) begin
               state_nxt = CSHK_CH_RUN;
            end
         end
         CSHK_CH_STBY: begin
            if (init_set && bus_recessive) begin
               state_nxt = CSHK_CH_INIT;
            end else if (stby_clr) begin
               state_nxt = CSHK_CH_RUN;
            end
         end
         default: state_nxt = CSHK_CH_RUN;
      endcase
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= CSHK_CH_INIT;
         pend_r <= CSHK_EVT_RST;
      end else begin
         state_r <= state_nxt;
         pend_r <= pend_nxt;
      end
   end
   a_pend_set_wins: assert property (@(posedge clk) disable iff (srst)
      (|(evt & pend_clr)) |=> (|(pend_r & $past(evt & pend_clr))))
      else $error("pending flag lost under clear");
   a_init_needs_rec: assert property (@(posedge clk) disable iff (srst)
      (state_r == CSHK_CH_RUN && !bus_recessive) |=> state_r == CSHK_CH_RUN)
      else $error("mode entered on dominant bus");
endmodule // cshk_chan

/* File: cshk_pkg.sv */
// Purpose: Constants and types for the CAN housekeeping block
// Assumes: Two channels, set/clear pair control writes
// Notes: Function
package cshk_pkg;
   localparam int CSHK_NCH = 2;
   localparam int CSHK_NEVT = 7;
   localparam int CSHK_TS_W = 16;
   localparam int CSHK_DLC_W = 4;
   localparam int CSHK_RADDR_W = 8;
   localparam int CSHK_RDATA_W = 16;
   localparam logic [CSHK_DLC_W-1:0] CSHK_DLC_ZERO = 4'h0;
   localparam logic [CSHK_TS_W-1:0] CSHK_TS_RST = 16'h0000;
   localparam logic [CSHK_TS_W-1:0] CSHK_TS_STEP = 16'h0001;
   localparam logic [CSHK_NEVT-1:0] CSHK_EVT_RST = 7'h00;
   // Pin select bits: one per shared pin, 1 selects the CAN function
   localparam int CSHK_PIN_TX1 = 0;
   localparam int CSHK_PIN_RX1 = 1;
   localparam int CSHK_PIN_TX2 = 2;
   localparam int CSHK_PIN_RX2 = 3;
   localparam logic [3:0] CSHK_PIN_RST = 4'h0;
   localparam logic CSHK_ADDR_NONE = 1'b0;
   typedef enum logic [2:0] {
      CSHK_CH_RUN = 3'b001,
      CSHK_CH_INIT = 3'b010,
      CSHK_CH_STBY = 3'b100
   } cshk_ch_state_t;
endpackage

/* File: cshk_top.sv */
// Purpose: CAN housekeeping: shutdown, flags, wake, stamps, pins
// Assumes: Host bits arrive as set/clear pulse pairs on ports
// Notes: Register reads are modelled by a select and data port
`timescale 1ns/1ps
module cshk_top
   import cshk_pkg::*;
#(
   parameter int NCH = cshk_pkg::CSHK_NCH,
   parameter int NEVT = cshk_pkg::CSHK_NEVT,
   parameter int TS_W = cshk_pkg::CSHK_TS_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Channel init and standby set/clear pairs
   input wire logic [NCH-1:0] init_set,
   input wire logic [NCH-1:0] init_clr,
   input wire logic [NCH-1:0] stby_set,
   input wire logic [NCH-1:0] stby_clr,
   input wire logic [NCH-1:0] timestamp_mode,
   input wire logic [NCH-1:0] rx_dominant_polarity,
   // Global status set/clear pairs
   input wire logic run_set,
   input wire logic run_clr,
   input wire logic goe_set,
   input wire logic goe_clr,
   // Stop control and wake
   input wire logic can_stop_control,
   input wire logic clocks_stopped,
   // Pin function select, one bit per shared pin
   input wire logic [3:0] pin_function_select_reg,
   input wire logic ch1_rx_pin,
   input wire logic ch2_rx_pin,
   input wire logic [NCH-1:0] core_tx,
   // Channel events and pending clears
   input wire logic [NEVT-1:0] ch1_evt,
   input wire logic [NEVT-1:0] ch2_evt,
   input wire logic [NEVT-1:0] ch1_pend_clr,
   input wire logic [NEVT-1:0] ch2_pend_clr,
   input wire logic [NCH-1:0] chan_access,
   // Receive store
   input wire logic [NCH-1:0] rx_eof,
   input wire logic [NCH-1:0] rx_remote,
   input wire logic [NCH-1:0] rx_ext_id,
   input wire logic [cshk_pkg::CSHK_DLC_W-1:0] rx_dlc,
   // Register read port
   input wire logic rd_en,
   input wire logic [cshk_pkg::CSHK_RADDR_W-1:0] rd_addr,
   input wire logic [cshk_pkg::CSHK_RDATA_W-1:0] rd_live,
   // Outputs
   output logic timestamp_run,
   output logic global_operation_enable,
   output logic [NCH-1:0] chan_in_init,
   output logic [NCH-1:0] chan_in_stby,
   output logic [NEVT-1:0] ch1_pending,
   output logic [NEVT-1:0] ch2_pending,
   output logic global_irq_r,
   output logic wakeup_r,
   output logic ch1_tx_pin,
   output logic ch2_tx_pin,
   output logic [cshk_pkg::CSHK_DLC_W-1:0] stored_dlc_r,
   output logic [TS_W-1:0] stamp_r,
   output logic stamp_valid_r,
   output logic [cshk_pkg::CSHK_RDATA_W-1:0] rd_data_r
);
   import cshk_pkg::*;
   logic run_r;
   logic goe_r;
   logic [TS_W-1:0] ts_cnt_r;
   logic [NCH-1:0] rx_prev_r;
   cshk_ch_state_t st [NCH];
   logic [NEVT-1:0] pend [NCH];
   logic [NCH-1:0] rx_int;
   logic [NCH-1:0] rx_recessive;
   logic [NCH-1:0] tx_int;
   logic [NCH-1:0] chan_init_w;
   logic [NCH-1:0] chan_stby_w;
   logic bus_edge;
   logic any_eof;
   logic ch_sel;
   logic stamp_ok;
   logic last_rd_v_r;
   logic [CSHK_RADDR_W-1:0] last_rd_addr_r;
   logic run_nxt;
   logic goe_nxt;

   // Set/clear pairs: only written positions change, set wins
   assign run_nxt = run_set | (run_r & ~run_clr);
   // No interlock between the bits: restart order is left to the host
   assign goe_nxt = goe_set | (goe_r & ~goe_clr);

   // Port mode forces internal signal low
   assign rx_int[0] = pin_function_select_reg[CSHK_PIN_RX1] & ch1_rx_pin;
   assign rx_int[1] = pin_function_select_reg[CSHK_PIN_RX2] & ch2_rx_pin;
   assign tx_int[0] = pin_function_select_reg[CSHK_PIN_TX1] & core_tx[0];
   assign tx_int[1] = pin_function_select_reg[CSHK_PIN_TX2] & core_tx[1];
   // Low dominant means forced-low input reads dominant
   assign rx_recessive = rx_int ^ rx_dominant_polarity;

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         cshk_chan #(.NEVT(NEVT)) u_ch (
            .clk(clk),
            .srst(srst),
            .init_set(init_set[g]),
            .init_clr(init_clr[g]),
            .stby_set(stby_set[g]),
            .stby_clr(stby_clr[g]),
            .bus_recessive(rx_recessive[g]),
            .evt(g == 0 ? ch1_evt : ch2_evt),
            .pend_clr(g == 0 ? ch1_pend_clr : ch2_pend_clr),
            .pend_r(pend[g]),
            .state_r(st[g])
         );
         assign chan_init_w[g] = (st[g] == CSHK_CH_INIT);
         assign chan_stby_w[g] = (st[g] == CSHK_CH_STBY);
      end
   endgenerate

   // Wake on any bus level change while clocks are held and stop control is set
   assign bus_edge = |(rx_int ^ rx_prev_r);
   assign any_eof = |rx_eof;
   assign ch_sel = rx_eof[1] & ~rx_eof[0];
   // Stamp only meaningful with counter running and mode set
   assign stamp_ok = run_r & timestamp_mode[ch_sel];

   always_ff @(posedge clk) begin
      if (srst) begin
         run_r <= 1'b0;
         goe_r <= 1'b0;
         ts_cnt_r <= CSHK_TS_RST;
         // Pins reset to port mode, so internal rx idles low: no false edge
         rx_prev_r <= '0;
      end else begin
         run_r <= run_nxt;
         goe_r <= goe_nxt;
         rx_prev_r <= rx_int;
         if (run_r) begin
            ts_cnt_r <= ts_cnt_r + CSHK_TS_STEP;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         timestamp_run <= 1'b0;
         global_operation_enable <= 1'b0;
         chan_in_init <= '0;
         chan_in_stby <= '0;
         ch1_pending <= CSHK_EVT_RST;
         ch2_pending <= CSHK_EVT_RST;
         ch1_tx_pin <= 1'b0;
         ch2_tx_pin <= 1'b0;
         global_irq_r <= 1'b0;
         wakeup_r <= 1'b0;
      end else begin
         timestamp_run <= run_nxt;
         global_operation_enable <= goe_nxt;
         chan_in_init <= chan_init_w;
         chan_in_stby <= chan_stby_w;
         ch1_pending <= pend[0];
         ch2_pending <= pend[1];
         ch1_tx_pin <= tx_int[0];
         ch2_tx_pin <= tx_int[1];
         global_irq_r <= (|chan_access) & ~goe_r;
         wakeup_r <= clocks_stopped & can_stop_control & bus_edge;
      end
   end

   // Capture at end of frame only; start of frame has no input
   always_ff @(posedge clk) begin
      if (srst) begin
         stamp_r <= CSHK_TS_RST;
         stamp_valid_r <= 1'b0;
         stored_dlc_r <= CSHK_DLC_ZERO;
      end else if (any_eof) begin
         stamp_r <= ts_cnt_r;
         stamp_valid_r <= stamp_ok;
         stored_dlc_r <= (rx_remote[ch_sel] & rx_ext_id[ch_sel]) ? CSHK_DLC_ZERO : rx_dlc;
      end
   end

   // Repeat read of one address returns the held value
   always_ff @(posedge clk) begin
      if (srst) begin
         last_rd_v_r <= CSHK_ADDR_NONE;
         last_rd_addr_r <= '0;
         rd_data_r <= '0;
      end else if (rd_en) begin
         last_rd_v_r <= 1'b1;
         last_rd_addr_r <= rd_addr;
         if (!(last_rd_v_r && last_rd_addr_r == rd_addr)) begin
            rd_data_r <= rd_live;
         end
      end
   end

   a_run_clear_stops: assert property (@(posedge clk) disable iff (srst)
      (run_clr && !run_set) |=> !timestamp_run)
      else $error("run bit survived clear");
   a_goe_keeps: assert property (@(posedge clk) disable iff (srst)
      (!goe_set && !goe_clr) |=> global_operation_enable == $past(goe_r))
      else $error("enable changed without write");
   a_goe_clear: assert property (@(posedge clk) disable iff (srst)
      (goe_clr && !goe_set) |=> !global_operation_enable)
      else $error("enable survived clear");
   a_port_tx_low: assert property (@(posedge clk) disable iff (srst)
      !pin_function_select_reg[CSHK_PIN_TX1] |=> !ch1_tx_pin)
      else $error("tx not low in port mode");
   a_remote_dlc_zero: assert property (@(posedge clk) disable iff (srst)
      (rx_eof[0] && rx_remote[0] && rx_ext_id[0]) |=> stored_dlc_r == CSHK_DLC_ZERO)
      else $error("remote dlc not zero");
   a_stamp_invalid: assert property (@(posedge clk) disable iff (srst)
      (any_eof && !run_r) |=> !stamp_valid_r)
      else $error("stamp marked valid while stopped");
   a_wake_on_edge: assert property (@(posedge clk) disable iff (srst)
      (clocks_stopped && can_stop_control && bus_edge) |=> wakeup_r)
      else $error("no wake on bus change");
   a_access_irq: assert property (@(posedge clk) disable iff (srst)
      (chan_access[0] && !goe_r) |=> global_irq_r)
      else $error("no irq on disabled access");
   a_stale_read: assert property (@(posedge clk) disable iff (srst)
      (rd_en && last_rd_v_r && rd_addr == last_rd_addr_r) |=> $stable(rd_data_r))
      else $error("repeat read updated");
   a_port_no_init: assert property (@(posedge clk) disable iff (srst)
      (!pin_function_select_reg[CSHK_PIN_RX1] && !rx_dominant_polarity[0]
       && st[0] == CSHK_CH_RUN) |=> st[0] == CSHK_CH_RUN)
      else $error("init entered in port mode");
endmodule // cshk_top

/* File: cshk_top_tb_top.sv */
// Purpose: Self-checking bench for the CAN housekeeping block
// Assumes: Inputs change at the falling edge only
// Notes: Pulse outputs are looked at in their one high cycle
`timescale 1ns/1ps
module cshk_top_tb_top;
   import cshk_pkg::*;
   logic clk = 1'b0, srst = 1'b1;
   logic [1:0] init_set = '0, init_clr = '0, stby_set = '0, stby_clr = '0;
   logic [1:0] timestamp_mode = '0, rx_dominant_polarity = '0, core_tx = '0;
   logic [1:0] chan_access = '0, rx_eof = '0, rx_remote = '0, rx_ext_id = '0, dom = '0;
   logic run_set = 1'b0, run_clr = 1'b0, goe_set = 1'b0, goe_clr = 1'b0;
   logic can_stop_control = 1'b0, clocks_stopped = 1'b0, rd_en = 1'b0;
   logic [3:0] pin_function_select_reg = 4'h0, rx_dlc = 4'h0;
   logic [6:0] ch1_evt = '0, ch2_evt = '0, ch1_pend_clr = '0, ch2_pend_clr = '0;
   logic [7:0] rd_addr = 8'h00;
   logic [15:0] rd_live = 16'h0000, rd_data_r, stamp_r, s0;
   logic ch1_rx_pin, ch2_rx_pin, timestamp_run, global_operation_enable;
   logic global_irq_r, wakeup_r, ch1_tx_pin, ch2_tx_pin, stamp_valid_r;
   logic [1:0] chan_in_init, chan_in_stby;
   logic [6:0] ch1_pending, ch2_pending;
   logic [3:0] stored_dlc_r;
   int fails = 0, tests_run = 0, cycles = 0;
   always #2.5 clk = ~clk;
   cshk_top DUT (.clk(clk), .srst(srst), .init_set(init_set), .init_clr(init_clr),
      .stby_set(stby_set), .stby_clr(stby_clr), .timestamp_mode(timestamp_mode),
      .rx_dominant_polarity(rx_dominant_polarity), .run_set(run_set), .run_clr(run_clr),
      .goe_set(goe_set), .goe_clr(goe_clr), .can_stop_control(can_stop_control),
      .clocks_stopped(clocks_stopped), .pin_function_select_reg(pin_function_select_reg),
      .ch1_rx_pin(ch1_rx_pin), .ch2_rx_pin(ch2_rx_pin), .core_tx(core_tx),
      .ch1_evt(ch1_evt), .ch2_evt(ch2_evt), .ch1_pend_clr(ch1_pend_clr),
      .ch2_pend_clr(ch2_pend_clr), .chan_access(chan_access), .rx_eof(rx_eof),
      .rx_remote(rx_remote), .rx_ext_id(rx_ext_id), .rx_dlc(rx_dlc), .rd_en(rd_en),
      .rd_addr(rd_addr), .rd_live(rd_live), .timestamp_run(timestamp_run),
      .global_operation_enable(global_operation_enable), .chan_in_init(chan_in_init),
      .chan_in_stby(chan_in_stby), .ch1_pending(ch1_pending), .ch2_pending(ch2_pending),
      .global_irq_r(global_irq_r), .wakeup_r(wakeup_r), .ch1_tx_pin(ch1_tx_pin),
      .ch2_tx_pin(ch2_tx_pin), .stored_dlc_r(stored_dlc_r), .stamp_r(stamp_r),
      .stamp_valid_r(stamp_valid_r), .rd_data_r(rd_data_r));
   cshk_bus_model bus (.dom(dom), .pol(rx_dominant_polarity), .ch1_rx_pin(ch1_rx_pin),
      .ch2_rx_pin(ch2_rx_pin));
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // One-cycle global set/clear pulses, then one idle edge
   task automatic host(input logic rsv, input logic rcv, input logic gsv, input logic gcv);
      run_set = rsv;
      run_clr = rcv;
      goe_set = gsv;
      goe_clr = gcv;
      tick(1);
      {run_set, run_clr, goe_set, goe_clr} = 4'h0;
      tick(1);
   endtask
   // One-cycle channel mode pulses, then one idle edge
   task automatic mode(input logic [1:0] isv, input logic [1:0] icv, input logic [1:0] ssv,
      input logic [1:0] scv);
      init_set = isv;
      init_clr = icv;
      stby_set = ssv;
      stby_clr = scv;
      tick(1);
      {init_set, init_clr, stby_set, stby_clr} = 8'h00;
      tick(1);
   endtask
   task automatic final_report();
      if (fails == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         final_report();
      end
   end
   // Host restart in the required order, then a run set/clear collision
   task automatic t_global();
      check("init_rst", chan_in_init, 16'h0003);
      check("run_rst", timestamp_run, 16'h0000);
      host(1'b0, 1'b0, 1'b1, 1'b0);
      check("goe_set", global_operation_enable, 16'h0001);
      check("run_kept", timestamp_run, 16'h0000);
      host(1'b1, 1'b0, 1'b0, 1'b0);
      check("run_set", timestamp_run, 16'h0001);
      host(1'b1, 1'b1, 1'b0, 1'b0);
      check("run_win", timestamp_run, 16'h0001);
      check("goe_kept", global_operation_enable, 16'h0001);
   endtask
   // Mode entry needs a recessive bus; port mode forces rx low
   task automatic t_mode();
      pin_function_select_reg = 4'hf;
      mode(2'h0, 2'h3, 2'h0, 2'h0);
      tick(2);
      check("init_rel", chan_in_init, 16'h0000);
      dom = 2'h1;
      mode(2'h3, 2'h0, 2'h0, 2'h0);
      tick(2);
      check("init_dom", chan_in_init, 16'h0002);
      mode(2'h0, 2'h0, 2'h1, 2'h0);
      tick(2);
      check("stby_dom", chan_in_stby, 16'h0000);
      dom = 2'h0;
      pin_function_select_reg = 4'h5;
      core_tx = 2'h3;
      mode(2'h1, 2'h0, 2'h0, 2'h0);
      tick(2);
      check("init_port", chan_in_init, 16'h0002);
      check("tx_can", {ch2_tx_pin, ch1_tx_pin}, 16'h0003);
      pin_function_select_reg = 4'ha;
      tick(2);
      check("tx_port", {ch2_tx_pin, ch1_tx_pin}, 16'h0000);
      pin_function_select_reg = 4'hf;
      mode(2'h0, 2'h0, 2'h1, 2'h0);
      tick(2);
      check("stby_in", chan_in_stby, 16'h0001);
      mode(2'h0, 2'h0, 2'h0, 2'h1);
      mode(2'h1, 2'h0, 2'h0, 2'h0);
      tick(2);
      check("init_set", chan_in_init, 16'h0003);
   endtask
   // Polled receive: flag first, then clear; event beats clear
   task automatic t_pend();
      ch1_evt = 7'h02;
      ch1_pend_clr = 7'h02;
      ch2_evt = 7'h40;
      tick(1);
      {ch1_evt, ch2_evt, ch1_pend_clr} = '0;
      tick(3);
      check("pend_win", ch1_pending, 16'h0002);
      check("pend_ch2", ch2_pending, 16'h0040);
      ch1_pend_clr = 7'h02;
      tick(1);
      ch1_pend_clr = 7'h00;
      tick(3);
      check("pend_clr", ch1_pending, 16'h0000);
      check("pend_other", ch2_pending, 16'h0040);
   endtask
   task automatic t_irq_wake();
      chan_access = 2'h1;
      tick(1);
      check("irq_on", global_irq_r, 16'h0000);
      chan_access = 2'h0;
      tick(1);
      // Shutdown: channels already in init, then stamp, then global
      host(1'b0, 1'b1, 1'b0, 1'b0);
      check("run_stop", timestamp_run, 16'h0000);
      host(1'b0, 1'b0, 1'b0, 1'b1);
      check("goe_clr", global_operation_enable, 16'h0000);
      chan_access = 2'h3;
      tick(1);
      chan_access = 2'h0;
      check("irq_hi", global_irq_r, 16'h0001);
      tick(1);
      check("irq_lo", global_irq_r, 16'h0000);
      clocks_stopped = 1'b1;
      can_stop_control = 1'b1;
      tick(1);
      dom = 2'h1;
      tick(1);
      check("wake_hi", wakeup_r, 16'h0001);
      tick(1);
      check("wake_lo", wakeup_r, 16'h0000);
      can_stop_control = 1'b0;
      dom = 2'h0;
      tick(2);
      check("wake_off", wakeup_r, 16'h0000);
      clocks_stopped = 1'b0;
   endtask
   task automatic store(input logic rem, input logic ext, input logic [3:0] dlc);
      rx_eof = 2'h1;
      rx_remote = {1'b0, rem};
      rx_ext_id = {1'b0, ext};
      rx_dlc = dlc;
      tick(1);
      rx_eof = 2'h0;
      tick(2);
   endtask
   task automatic t_store();
      timestamp_mode = 2'h1;
      host(1'b0, 1'b0, 1'b1, 1'b0);
      host(1'b1, 1'b0, 1'b0, 1'b0);
      store(1'b1, 1'b1, 4'h8);
      s0 = stamp_r;
      check("dlc_ext", stored_dlc_r, 16'h0000);
      check("valid_on", stamp_valid_r, 16'h0001);
      timestamp_mode = 2'h0;
      store(1'b1, 1'b0, 4'h8);
      check("stamp_gap", stamp_r - s0, 16'h0003);
      check("dlc_std", stored_dlc_r, 16'h0008);
      check("valid_mode", stamp_valid_r, 16'h0000);
      host(1'b0, 1'b1, 1'b0, 1'b0);
      timestamp_mode = 2'h1;
      store(1'b0, 1'b0, 4'h3);
      check("valid_run", stamp_valid_r, 16'h0000);
      check("dlc_data", stored_dlc_r, 16'h0003);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] live, input logic [15:0] exp);
      rd_en = 1'b1;
      rd_addr = a;
      rd_live = live;
      tick(1);
      rd_en = 1'b0;
      tick(1);
      check("rd_data", rd_data_r, exp);
   endtask
   initial begin
      tick(3);
      srst = 1'b0;
      tick(2);
      t_global();
      t_mode();
      t_pend();
      t_irq_wake();
      t_store();
      rd(8'h10, 16'h1234, 16'h1234);
      rd(8'h10, 16'h5678, 16'h1234);
      rd(8'h12, 16'h9abc, 16'h9abc);
      rd(8'h10, 16'h5678, 16'h5678);
      final_report();
   end
endmodule // cshk_top_tb_top
